// ---- logic/ssf_cfg.svh ----
// Constants of the sensor sample buffer: register offsets, field positions, sizes.
// Assumes an internal register port (address, write strobe, read strobe) on one clock.
`ifndef SSF_CFG_SVH
`define SSF_CFG_SVH
`define SSF_DEPTH 32
`define SSF_PTR_W 5
`define SSF_LVL_W 6
`define SSF_ENTRY_W 40
`define SSF_ADDR_W 7
`define SSF_ADR_INT_CFG 7'h0b
`define SSF_ADR_CTRL2 7'h11
`define SSF_ADR_CTRL3 7'h12
`define SSF_ADR_BUF_CTRL 7'h14
`define SSF_ADR_BUF_STATE 7'h26
`define SSF_ADR_OUT_FIRST 7'h28
`define SSF_ADR_OUT_LAST 7'h2c
`define SSF_ADR_PRESS_MID 7'h29
`define SSF_ADR_PRESS_HIGH 7'h2a
`define SSF_ADR_TEMP_LOW 7'h2b
`define SSF_ADR_STEP 7'h01
`define SSF_LVL_TWO 6'h02
`define SSF_CTRL2_EN_BIT 6
`define SSF_CTRL2_STOP_BIT 5
`define SSF_CTRL3_OVR_BIT 3
`define SSF_CTRL3_WTM_BIT 4
`define SSF_CTRL2_RESET 8'h10
`define SSF_MODE_LSB 5
`define SSF_LVL_FULL 6'h20
`define SSF_LVL_ONE 6'h01
`define SSF_PTR_ONE 5'h01
`endif

// ---- logic/ssf_pkg.sv ----
// Types of the sensor sample buffer.
// Assumes ssf_cfg.svh on the include path.
`include "ssf_cfg.svh"
package ssf_pkg;
    typedef enum logic [2:0] {
        SSF_BYPASS = 3'h0,
        SSF_FIFO = 3'h1,
        SSF_STREAM = 3'h2,
        SSF_STR_TO_FIFO = 3'h3,
        SSF_BYP_TO_STR = 3'h4,
        SSF_DYN_STREAM = 3'h6,
        SSF_BYP_TO_FIFO = 3'h7
    } ssf_mode_e;
    // Effective behaviour after trigger resolution, one-hot
    typedef enum logic [2:0] {
        SSF_EFF_CLEAR = 3'h1,
        SSF_EFF_FIFO = 3'h2,
        SSF_EFF_STREAM = 3'h4
    } ssf_eff_e;
    typedef logic [`SSF_ENTRY_W-1:0] ssf_entry_t;
endpackage : ssf_pkg

// ---- logic/ssf_store.sv ----
// Entry storage of the sample buffer: flip-flop slots with one write port.
// Assumes write index and read index from the controller on the same clock.
`timescale 1ns/100ps
`default_nettype none
`include "ssf_cfg.svh"
module ssf_store (
    input wire logic clk_sys_in,
    input wire logic wr_in,
    input wire logic [`SSF_PTR_W-1:0] wr_idx_in,
    input wire ssf_pkg::ssf_entry_t wr_data_in,
    input wire logic [`SSF_PTR_W-1:0] rd_idx_in,
    output var ssf_pkg::ssf_entry_t rd_data_out
);
    import ssf_pkg::*;
    ssf_entry_t slot_reg [`SSF_DEPTH];
    genvar gi;
    generate
        for (gi = 0; gi < `SSF_DEPTH; gi++) begin : g_slot
            always_ff @(posedge clk_sys_in) begin
                if (wr_in && wr_idx_in == `SSF_PTR_W'(gi)) begin
                    slot_reg[gi] <= wr_data_in;
                end
            end
        end
    endgenerate
    assign rd_data_out = slot_reg[rd_idx_in];
endmodule : ssf_store
`default_nettype wire

// ---- logic/ssf_top.sv ----
// Sensor sample buffer with its control, status and output registers.
// Assumes a byte register port from the serial interface (strobes last one cycle)
// and sample and trigger inputs from measurement and threshold logic, same clock.
`timescale 1ns/100ps
`default_nettype none
`include "ssf_cfg.svh"
module ssf_top (
    input wire logic clk_sys_in,
    input wire logic nrst_in,
    input wire logic [`SSF_ADDR_W-1:0] reg_addr_in,
    input wire logic reg_wr_in,
    input wire logic [7:0] reg_wdata_in,
    input wire logic reg_rd_in,
    output logic [7:0] reg_rdata_out,
    output logic [`SSF_ADDR_W-1:0] reg_next_addr_out,
    input wire logic sample_valid_in,
    input wire logic [23:0] sample_pressure_in,
    input wire logic [15:0] sample_temperature_in,
    input wire logic interrupt_active_flag_in,
    output logic data_ready_irq_pin_out,
    output logic [7:0] interrupt_generator_config_out
);
    import ssf_pkg::*;
    logic [7:0] control_two_reg;
    logic [7:0] control_three_reg;
    logic [7:0] buffer_control_reg;
    logic [`SSF_PTR_W-1:0] head_reg;
    logic [`SSF_LVL_W-1:0] fill_level_reg;
    logic kept_reg;
    logic overrun_flag_reg;
    ssf_entry_t out_reg;
    logic [7:0] rdata_reg;
    logic [`SSF_ADDR_W-1:0] next_addr_reg;
    logic irq_reg;
    logic [7:0] int_cfg_reg;

    ssf_mode_e mode;
    ssf_eff_e eff;
    wire buf_en = control_two_reg[`SSF_CTRL2_EN_BIT];
    wire stop_at_watermark = control_two_reg[`SSF_CTRL2_STOP_BIT];
    wire overrun_irq_enable = control_three_reg[`SSF_CTRL3_OVR_BIT];
    wire watermark_irq_enable = control_three_reg[`SSF_CTRL3_WTM_BIT];
    wire [4:0] watermark_level = buffer_control_reg[4:0];
    assign mode = ssf_mode_e'(buffer_control_reg[7:`SSF_MODE_LSB]);

    // Trigger modes resolve into one of three behaviours
    always_comb begin
        case (mode)
            SSF_FIFO: eff = SSF_EFF_FIFO;
            SSF_STREAM, SSF_DYN_STREAM: eff = SSF_EFF_STREAM;
            SSF_STR_TO_FIFO: eff = interrupt_active_flag_in ? SSF_EFF_FIFO
                                                            : SSF_EFF_STREAM;
            SSF_BYP_TO_STR: eff = interrupt_active_flag_in ? SSF_EFF_STREAM
                                                           : SSF_EFF_CLEAR;
            SSF_BYP_TO_FIFO: eff = interrupt_active_flag_in ? SSF_EFF_FIFO
                                                            : SSF_EFF_CLEAR;
            default: eff = SSF_EFF_CLEAR;
        endcase
    end
    wire active = buf_en && (eff != SSF_EFF_CLEAR);
    wire dyn = (mode == SSF_DYN_STREAM);

    // Depth limited by watermark when stop bit is set
    wire [`SSF_LVL_W-1:0] depth = stop_at_watermark ? ({1'b0, watermark_level} + `SSF_LVL_ONE)
                                                    : `SSF_LVL_FULL;
    wire full = (fill_level_reg >= depth);
    wire sample_in = sample_valid_in && active;
    wire store = sample_in && !(eff == SSF_EFF_FIFO && full);
    wire overwrite = store && (fill_level_reg == `SSF_LVL_FULL);

    // Every mode but dynamic stream keeps the last-read slot counted once a new sample lands
    wire reuse_kept = store && kept_reg && !dyn && (fill_level_reg == '0);
    wire [`SSF_PTR_W-1:0] head_eff = reuse_kept ? (head_reg - `SSF_PTR_ONE) : head_reg;
    wire [`SSF_PTR_W-1:0] wr_idx = head_eff + fill_level_reg[`SSF_PTR_W-1:0]
                                   + (reuse_kept ? `SSF_PTR_ONE : '0);

    wire is_out = reg_addr_in >= `SSF_ADR_OUT_FIRST && reg_addr_in <= `SSF_ADR_OUT_LAST;
    wire rd_first = reg_rd_in && reg_addr_in == `SSF_ADR_OUT_FIRST;
    wire rd_last = reg_rd_in && reg_addr_in == `SSF_ADR_OUT_LAST;
    wire pop = rd_last && fill_level_reg != '0 && active;
    wire mode_wr = reg_wr_in && reg_addr_in == `SSF_ADR_BUF_CTRL;
    wire clear = !buf_en || eff == SSF_EFF_CLEAR
                 || (mode_wr && reg_wdata_in[7:`SSF_MODE_LSB] == SSF_BYPASS);

    ssf_entry_t head_data;
    wire ssf_entry_t sample_word = {sample_pressure_in, sample_temperature_in};
    ssf_store u_store (
        .clk_sys_in(clk_sys_in),
        .wr_in(store),
        .wr_idx_in(wr_idx),
        .wr_data_in(sample_word),
        .rd_idx_in(head_reg),
        .rd_data_out(head_data)
    );

    // Level bookkeeping
    logic [`SSF_LVL_W-1:0] fill_level_next;
    logic [`SSF_PTR_W-1:0] head_next;
    always_comb begin
        fill_level_next = fill_level_reg;
        head_next = head_eff;
        if (store && !overwrite) begin
            fill_level_next = fill_level_next + (reuse_kept ? `SSF_LVL_TWO : `SSF_LVL_ONE);
        end
        if (overwrite) begin
            head_next = head_next + `SSF_PTR_ONE;
        end
        if (pop && !overwrite) begin
            fill_level_next = fill_level_next - `SSF_LVL_ONE;
            head_next = head_next + `SSF_PTR_ONE;
        end
    end

    wire watermark_reached_flag = watermark_level != '0
                                  && fill_level_reg >= {1'b0, watermark_level};
    wire [7:0] state_byte = {watermark_reached_flag, overrun_flag_reg, fill_level_reg};
    // Pressure bytes pass unchanged, so the two's complement scale is kept
    wire [7:0] out_byte = reg_addr_in == `SSF_ADR_OUT_FIRST ? out_reg[23:16] :
                          reg_addr_in == `SSF_ADR_PRESS_MID ? out_reg[31:24] :
                          reg_addr_in == `SSF_ADR_PRESS_HIGH ? out_reg[39:32] :
                          reg_addr_in == `SSF_ADR_TEMP_LOW ? out_reg[7:0] : out_reg[15:8];
    wire [7:0] rd_byte = reg_addr_in == `SSF_ADR_INT_CFG ? int_cfg_reg :
                         reg_addr_in == `SSF_ADR_CTRL2 ? control_two_reg :
                         reg_addr_in == `SSF_ADR_CTRL3 ? control_three_reg :
                         reg_addr_in == `SSF_ADR_BUF_CTRL ? buffer_control_reg :
                         reg_addr_in == `SSF_ADR_BUF_STATE ? state_byte :
                         is_out ? out_byte : 8'h00;
    wire [`SSF_ADDR_W-1:0] next_addr = rd_last ? `SSF_ADR_OUT_FIRST
                                               : reg_addr_in + `SSF_ADR_STEP;
    wire irq_next = (watermark_irq_enable && watermark_reached_flag)
                    || (overrun_irq_enable && overrun_flag_reg);

    always_ff @(posedge clk_sys_in) begin
        if (!nrst_in) begin
            control_two_reg <= `SSF_CTRL2_RESET;
            control_three_reg <= 8'h00;
            buffer_control_reg <= 8'h00;
            int_cfg_reg <= 8'h00;
        end else if (reg_wr_in) begin
            if (reg_addr_in == `SSF_ADR_CTRL2) control_two_reg <= reg_wdata_in;
            if (reg_addr_in == `SSF_ADR_CTRL3) control_three_reg <= reg_wdata_in;
            if (reg_addr_in == `SSF_ADR_BUF_CTRL) buffer_control_reg <= reg_wdata_in;
            if (reg_addr_in == `SSF_ADR_INT_CFG) int_cfg_reg <= reg_wdata_in;
        end
    end

    always_ff @(posedge clk_sys_in) begin
        if (!nrst_in || clear) begin
            head_reg <= '0;
            fill_level_reg <= '0;
            kept_reg <= 1'b0;
            overrun_flag_reg <= 1'b0;
        end else begin
            head_reg <= head_next;
            fill_level_reg <= fill_level_next;
            if (pop && fill_level_reg == `SSF_LVL_ONE && !store) kept_reg <= 1'b1;
            else if (store) kept_reg <= 1'b0;
            // Set wins; the flag is dropped when the buffer is read below full
            if (overwrite) overrun_flag_reg <= 1'b1;
            else if (pop) overrun_flag_reg <= 1'b0;
        end
    end

    always_ff @(posedge clk_sys_in) begin
        if (!nrst_in) begin
            out_reg <= '0;
            rdata_reg <= 8'h00;
            next_addr_reg <= `SSF_ADR_OUT_FIRST;
            irq_reg <= 1'b0;
        end else begin
            // Bypass: each sample lands straight in the output window
            if (!active && sample_valid_in) out_reg <= sample_word;
            else if (active && rd_first && fill_level_reg != '0) out_reg <= head_data;
            if (reg_rd_in) rdata_reg <= rd_first && active && fill_level_reg != '0
                                        ? head_data[23:16] : rd_byte;
            if (reg_rd_in) next_addr_reg <= next_addr;
            irq_reg <= irq_next;
        end
    end

    assign reg_rdata_out = rdata_reg;
    assign reg_next_addr_out = next_addr_reg;
    assign data_ready_irq_pin_out = irq_reg;
    assign interrupt_generator_config_out = int_cfg_reg;


    property p_fifo_stops;
        @(posedge clk_sys_in) disable iff (!nrst_in)
        eff == SSF_EFF_FIFO && full && !pop && !clear
        |=> fill_level_reg == $past(fill_level_reg);
    endproperty
    a_fifo_stops: assert property (p_fifo_stops) else $error("fifo level grew past depth");

    property p_level_max;
        @(posedge clk_sys_in) disable iff (!nrst_in)
        1'b1
        |-> fill_level_reg <= `SSF_LVL_FULL;
    endproperty
    a_level_max: assert property (p_level_max) else $error("level above full");

    property p_wtm;
        @(posedge clk_sys_in) disable iff (!nrst_in)
        reg_rd_in && reg_addr_in == `SSF_ADR_BUF_STATE && watermark_level == '0
        |=> !reg_rdata_out[7];
    endproperty
    a_wtm: assert property (p_wtm) else $error("watermark flag with zero level");

    property p_clear;
        @(posedge clk_sys_in) disable iff (!nrst_in)
        clear
        |=> fill_level_reg == '0 && !overrun_flag_reg;
    endproperty
    a_clear: assert property (p_clear) else $error("buffer not cleared");

    property p_wrap;
        @(posedge clk_sys_in) disable iff (!nrst_in)
        rd_last
        |=> reg_next_addr_out == `SSF_ADR_OUT_FIRST;
    endproperty
    a_wrap: assert property (p_wrap) else $error("read address did not wrap");

    property p_ovr;
        @(posedge clk_sys_in) disable iff (!nrst_in)
        overwrite && !clear
        |=> overrun_flag_reg;
    endproperty
    a_ovr: assert property (p_ovr) else $error("overrun lost");

    property p_jump;
        @(posedge clk_sys_in) disable iff (!nrst_in)
        reuse_kept && !clear && !pop
        |=> fill_level_reg == `SSF_LVL_TWO;
    endproperty
    a_jump: assert property (p_jump) else $error("stream level did not jump to two");

    property p_irq;
        @(posedge clk_sys_in) disable iff (!nrst_in)
        overrun_irq_enable && overrun_flag_reg ##1 overrun_irq_enable
        |-> data_ready_irq_pin_out;
    endproperty
    a_irq: assert property (p_irq) else $error("overrun interrupt missing");

    property p_disabled_empty;
        @(posedge clk_sys_in) disable iff (!nrst_in)
        !buf_en
        |=> fill_level_reg == '0;
    endproperty
    a_disabled_empty: assert property (p_disabled_empty) else $error("disabled buffer filled");

    property p_bypass_window;
        @(posedge clk_sys_in) disable iff (!nrst_in)
        !active && sample_valid_in
        |=> out_reg == $past(sample_word);
    endproperty
    a_bypass_window: assert property (p_bypass_window) else $error("bypass window stale");

    property p_pop_level;
        @(posedge clk_sys_in) disable iff (!nrst_in)
        pop && !store && !clear
        |=> fill_level_reg == $past(fill_level_reg) - `SSF_LVL_ONE;
    endproperty
    a_pop_level: assert property (p_pop_level) else $error("read did not remove entry");

    property p_stop_depth;
        @(posedge clk_sys_in) disable iff (!nrst_in)
        stop_at_watermark && eff == SSF_EFF_FIFO && sample_in && fill_level_reg == depth && !pop
        && !clear |=> fill_level_reg == $past(fill_level_reg);
    endproperty
    a_stop_depth: assert property (p_stop_depth) else $error("level grew past watermark");

    property p_stream_store;
        @(posedge clk_sys_in) disable iff (!nrst_in)
        eff == SSF_EFF_STREAM && sample_in && !reuse_kept && fill_level_reg < `SSF_LVL_FULL
        && !pop && !clear |=> fill_level_reg == $past(fill_level_reg) + `SSF_LVL_ONE;
    endproperty
    a_stream_store: assert property (p_stream_store) else $error("stream sample not stored");

    property p_stream_full;
        @(posedge clk_sys_in) disable iff (!nrst_in)
        eff == SSF_EFF_STREAM && sample_in && fill_level_reg == `SSF_LVL_FULL && !clear
        |=> fill_level_reg == `SSF_LVL_FULL;
    endproperty
    a_stream_full: assert property (p_stream_full) else $error("full stream level changed");

    property p_state_level;
        @(posedge clk_sys_in) disable iff (!nrst_in)
        reg_rd_in && reg_addr_in == `SSF_ADR_BUF_STATE
        |=> reg_rdata_out[5:0] == $past(fill_level_reg);
    endproperty
    a_state_level: assert property (p_state_level) else $error("status level wrong");

    property p_state_ovr;
        @(posedge clk_sys_in) disable iff (!nrst_in)
        reg_rd_in && reg_addr_in == `SSF_ADR_BUF_STATE
        |=> reg_rdata_out[6] == $past(overrun_flag_reg);
    endproperty
    a_state_ovr: assert property (p_state_ovr) else $error("status overrun wrong");

    property p_irq_wtm;
        @(posedge clk_sys_in) disable iff (!nrst_in)
        watermark_irq_enable && watermark_reached_flag
        |=> data_ready_irq_pin_out;
    endproperty
    a_irq_wtm: assert property (p_irq_wtm) else $error("watermark interrupt missing");

    property p_read_oldest;
        @(posedge clk_sys_in) disable iff (!nrst_in)
        rd_first && active && fill_level_reg != '0
        |=> reg_rdata_out == $past(head_data[23:16]);
    endproperty
    a_read_oldest: assert property (p_read_oldest) else $error("first byte not oldest");
endmodule : ssf_top
`default_nettype wire

// ---- testbench/ssf_host.sv ----
// Host model: drives the register port of the sample buffer like a serial bridge.
// Assumes strobes taken on the rising edge and read data valid one cycle later.
`timescale 1ns/100ps
`default_nettype none
module ssf_host (
    input wire logic clk_sys_in,
    output logic [6:0] reg_addr_out,
    output logic reg_wr_out,
    output logic [7:0] reg_wdata_out,
    output logic reg_rd_out,
    input wire logic [7:0] reg_rdata_in
);
    initial begin
        reg_addr_out = 7'h00;
        reg_wr_out = 1'b0;
        reg_wdata_out = 8'h00;
        reg_rd_out = 1'b0;
    end
    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        @(posedge clk_sys_in);
        reg_addr_out <= a;
        reg_wdata_out <= d;
        reg_wr_out <= 1'b1;
        @(posedge clk_sys_in);
        reg_wr_out <= 1'b0;
        // Released data does not keep its last value
        reg_wdata_out <= ~d;
    endtask : wr
    task automatic rd(input logic [6:0] a, output logic [7:0] d);
        @(posedge clk_sys_in);
        reg_addr_out <= a;
        reg_rd_out <= 1'b1;
        @(posedge clk_sys_in);
        reg_rd_out <= 1'b0;
        @(negedge clk_sys_in);
        d = reg_rdata_in;
    endtask : rd
    // Whole entries only: five bytes from 28h to 2Ch, so repeated calls form the full drain
    task automatic rd_entry(output logic [39:0] e);
        logic [7:0] b;
        for (int i = 0; i < 5; i++) begin
            rd(7'(8'h28 + i), b);
            e[8*i+:8] = b;
        end
    endtask : rd_entry
endmodule : ssf_host
`default_nettype wire

// ---- testbench/testbench.sv ----
// Self-checking bench of the sample buffer against a queue model.
// Assumes the host model drives registers; samples and trigger come from here.
`timescale 1ns/100ps
`default_nettype none
`include "ssf_cfg.svh"
module testbench;
    import ssf_pkg::*;
    logic clk_sys_in, nrst_in, sample_valid_in, ia, wr, rd, irq;
    logic [6:0] addr, next_addr;
    logic [7:0] wdata, rdata, icfg, b;
    logic [23:0] press;
    logic [15:0] temp;
    logic [39:0] got;
    int n_mismatch, checks, seed = 5, mode, wtm, stop, ovr, kept;
    ssf_entry_t q[$], last_rd, last_byp;
    initial begin
        clk_sys_in = 1'b0;
        forever #25 clk_sys_in = ~clk_sys_in;
    end
    ssf_host host_u (.clk_sys_in(clk_sys_in), .reg_addr_out(addr), .reg_wr_out(wr),
        .reg_wdata_out(wdata), .reg_rd_out(rd), .reg_rdata_in(rdata));
    ssf_top dut_u (.clk_sys_in(clk_sys_in), .nrst_in(nrst_in), .reg_addr_in(addr),
        .reg_wr_in(wr), .reg_wdata_in(wdata), .reg_rd_in(rd), .reg_rdata_out(rdata),
        .reg_next_addr_out(next_addr), .sample_valid_in(sample_valid_in),
        .sample_pressure_in(press), .sample_temperature_in(temp),
        .interrupt_active_flag_in(ia), .data_ready_irq_pin_out(irq),
        .interrupt_generator_config_out(icfg));
    task automatic check(string name, logic [39:0] exp, logic [39:0] seen);
        checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask : check
    task automatic final_report();
        if (n_mismatch == 0 && checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : final_report
    function automatic void model(ssf_entry_t e);
        int eff;
        eff = (mode == 1 || (mode == 3 && ia) || (mode == 7 && ia)) ? 1 :
            (mode == 2 || mode == 3 || (mode == 4 && ia)) ? 2 : (mode == 6) ? 3 : 0;
        if (eff == 0) begin
            q.delete();
            last_byp = e;
        end else if (eff == 1) begin
            if (q.size() < (stop ? wtm + 1 : 32)) q.push_back(e);
        end else begin
            if (q.size() == 32) begin
                void'(q.pop_front());
                ovr = 1;
            end
            if (eff == 2 && q.size() == 0 && kept) q.push_back(last_rd);
            kept = 0;
            q.push_back(e);
        end
    endfunction : model
    task automatic push(input int n);
        ssf_entry_t e;
        repeat (n) begin
            e = 40'({$random(seed), $random(seed)});
            @(posedge clk_sys_in);
            sample_valid_in <= 1'b1;
            press <= e[23:0];
            temp <= e[39:24];
            @(posedge clk_sys_in);
            sample_valid_in <= 1'b0;
            model(e);
        end
    endtask : push
    // No sample crosses a mode write, so none needs discarding
    task automatic set_cfg(input int m, input int w, input int s);
        host_u.wr(`SSF_ADR_CTRL2, 8'h50 | 8'(s << 5));
        host_u.wr(`SSF_ADR_BUF_CTRL, 8'(m << 5 | w));
        mode = m;
        wtm = w;
        stop = s;
        if (m == 0) q.delete();
        if (m == 0) kept = 0;
    endtask : set_cfg
    task automatic chk_status();
        host_u.rd(`SSF_ADR_BUF_STATE, b);
        check("fill_level", 40'(q.size()), 40'(b[5:0]));
        check("watermark_reached_flag", 40'(wtm != 0 && q.size() >= wtm), 40'(b[7]));
        check("status_next_addr", 40'(`SSF_ADR_BUF_STATE + 7'h01), 40'(next_addr));
    endtask : chk_status
    task automatic read_entry();
        ssf_entry_t exp;
        exp = q.pop_front();
        host_u.rd_entry(got);
        check("entry", exp, got);
        check("next_addr", 40'h28, 40'(next_addr));
        last_rd = exp;
        ovr = 0;
        if (q.size() == 0 && mode != 6) kept = 1;
    endtask : read_entry
    initial begin
        repeat (100000) @(posedge clk_sys_in);
        n_mismatch++;
        final_report();
    end
    initial begin
        nrst_in = 1'b0;
        sample_valid_in = 1'b0;
        ia = 1'b0;
        press = 24'h000000;
        temp = 16'h0000;
        repeat (12) @(posedge clk_sys_in);
        nrst_in <= 1'b1;
        host_u.rd(`SSF_ADR_CTRL2, b);
        check("control_two", 40'h10, 40'(b));
        chk_status();
        host_u.rd(7'h30, b);
        check("unmapped", 40'h0, 40'(b));
        // Interrupt generator configuration written by the host, read back and seen at its output
        host_u.wr(`SSF_ADR_INT_CFG, 8'ha5);
        host_u.rd(`SSF_ADR_INT_CFG, b);
        check("interrupt_generator_config", 40'ha5, 40'(b));
        check("interrupt_generator_config_out", 40'ha5, 40'(icfg));
        set_cfg(1, 4, 0);
        host_u.wr(`SSF_ADR_CTRL3, 8'h10);
        push(5);
        chk_status();
        check("irq_watermark", 40'h1, 40'(irq));
        read_entry();
        chk_status();
        push(40);
        chk_status();
        set_cfg(0, 4, 0);
        chk_status();
        push(2);
        chk_status();
        host_u.rd_entry(got);
        check("bypass_window", last_byp, got);
        set_cfg(1, 3, 1);
        push(10);
        chk_status();
        set_cfg(0, 0, 0);
        set_cfg(2, 0, 0);
        host_u.wr(`SSF_ADR_CTRL3, 8'h08);
        push(35);
        host_u.rd(`SSF_ADR_BUF_STATE, b);
        check("overrun_flag", 40'h1, 40'(b[6]));
        check("irq_overrun", 40'h1, 40'(irq));
        repeat (32) read_entry();
        push(1);
        chk_status();
        repeat (2) read_entry();
        set_cfg(0, 0, 0);
        set_cfg(6, 0, 0);
        push(3);
        repeat (3) read_entry();
        push(1);
        chk_status();
        for (int i = 0; i < 3; i++) begin
            set_cfg(0, 0, 0);
            set_cfg(i == 0 ? 3 : i == 1 ? 4 : 7, 0, 0);
            push(2);
            chk_status();
            @(posedge clk_sys_in);
            ia <= 1'b1;
            push(2);
            chk_status();
            @(posedge clk_sys_in);
            ia <= 1'b0;
        end
        final_report();
    end
endmodule : testbench
`default_nettype wire
